// File: eecs_pkg.sv
// Constants, types and register map of the exception entry block.
// Assumes a single core clock and a pipeline that presents one request a cycle.
package eecs_pkg;
	typedef enum logic [2:0] {
		EXC_RESET, EXC_UNDEF, EXC_SWI, EXC_PABT, EXC_DABT, EXC_IRQ, EXC_FIQ
	} eecs_exc_t;

	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_FIQ = 5'h11;
	localparam logic [4:0] MODE_IRQ = 5'h12;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_ABT = 5'h17;
	localparam logic [4:0] MODE_UND = 5'h1B;
	localparam logic [4:0] MODE_SYS = 5'h1F;

	localparam int STATE_BIT = 5;
	localparam int MODE_LSB  = 0;
	localparam int IRQ_DIS_BIT = 7;
	localparam int FIQ_DIS_BIT = 6;
	localparam logic [31:0] STATUS_RESET = 32'h000000D3;

	localparam logic [31:0] VEC_RESET = 32'h00000000;
	localparam logic [31:0] VEC_UNDEF = 32'h00000004;
	localparam logic [31:0] VEC_SWI   = 32'h00000008;
	localparam logic [31:0] VEC_PABT  = 32'h0000000C;
	localparam logic [31:0] VEC_DABT  = 32'h00000010;
	localparam logic [31:0] VEC_IRQ   = 32'h00000018;
	localparam logic [31:0] VEC_FIQ   = 32'h0000001C;

	localparam logic [31:0] OFS_STD4 = 32'h00000004;
	localparam logic [31:0] OFS_CMP2 = 32'h00000002;

	localparam logic [7:0] CSWI_TOP = 8'hDF;
	localparam logic [3:0] SSWI_COND_TOP = 4'hF;

	// Register map
	localparam logic [3:0] REG_STATUS  = 4'h0;
	localparam logic [3:0] REG_SAVED   = 4'h1;
	localparam logic [3:0] REG_LINK    = 4'h2;
	localparam logic [3:0] REG_PC      = 4'h3;
	localparam logic [3:0] REG_SWINUM  = 4'h4;
	localparam logic [3:0] REG_EVT     = 4'h5;
	localparam logic [3:0] REG_EVT_CLR = 4'h6;
	localparam logic [3:0] REG_EVT_EN  = 4'h7;
	localparam logic [3:0] REG_USR_LR  = 4'h8;

	localparam int EVT_W = 7;

	typedef enum logic [1:0] {ST_IDLE, ST_LINK, ST_VECTOR} eecs_phase_t;
endpackage

// File: eecs_exception_entry.sv
// Exception entry sequencer with banked link and saved status words.
// Assumes the pipeline holds its request until busy drops and supplies pc and opcode.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module eecs_exception_entry
	import eecs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        exc_req,
	input  wire logic [2:0]  exc_kind,
	input  wire logic [31:0] cur_pc,
	input  wire logic [31:0] swi_opcode,
	input  wire logic        bl_req,
	input  wire logic [31:0] bl_target,
	input  wire logic        bx_req,
	input  wire logic [31:0] bx_target,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	output logic [31:0]      fetch_pc,
	output logic             fetch_load,
	output logic [31:0]      status_word,
	output logic [31:0]      link_out,
	output logic             busy,
	output logic             irq
);
	typedef struct packed {
		eecs_phase_t phase;
		eecs_exc_t   kind;
		logic [31:0] status;
		logic [31:0] saved_fiq;
		logic [31:0] saved_irq;
		logic [31:0] saved_svc;
		logic [31:0] saved_abt;
		logic [31:0] saved_und;
		logic [31:0] lr_usr;
		logic [31:0] lr_fiq;
		logic [31:0] lr_irq;
		logic [31:0] lr_svc;
		logic [31:0] lr_abt;
		logic [31:0] lr_und;
		logic [31:0] ret_addr;
		logic [23:0] swi_num;
		logic [31:0] fetch_pc;
		logic        fetch_load;
		logic [31:0] rdata;
		logic [31:0] link_out;
		logic [EVT_W-1:0] evt;
		logic [EVT_W-1:0] evt_en;
		logic        irq;
		logic        busy;
	} eecs_state_t;

	eecs_state_t s_q;
	eecs_state_t s_d;

	function automatic logic [4:0] mode_of(input eecs_exc_t k);
		case (k)
			EXC_FIQ:            mode_of = MODE_FIQ;
			EXC_IRQ:            mode_of = MODE_IRQ;
			EXC_PABT, EXC_DABT: mode_of = MODE_ABT;
			EXC_UNDEF:          mode_of = MODE_UND;
			default:            mode_of = MODE_SVC; // Never MODE_SYS
		endcase
	endfunction

	function automatic logic [31:0] vec_of(input eecs_exc_t k);
		case (k)
			EXC_UNDEF: vec_of = VEC_UNDEF;
			EXC_SWI:   vec_of = VEC_SWI;
			EXC_PABT:  vec_of = VEC_PABT;
			EXC_DABT:  vec_of = VEC_DABT;
			EXC_IRQ:   vec_of = VEC_IRQ;
			EXC_FIQ:   vec_of = VEC_FIQ;
			default:   vec_of = VEC_RESET;
		endcase
	endfunction

	// Current link register as seen by the active mode; system shares the user copy
	function automatic logic [31:0] cur_lr(input eecs_state_t s);
		case (s.status[4:0])
			MODE_FIQ: cur_lr = s.lr_fiq;
			MODE_IRQ: cur_lr = s.lr_irq;
			MODE_SVC: cur_lr = s.lr_svc;
			MODE_ABT: cur_lr = s.lr_abt;
			MODE_UND: cur_lr = s.lr_und;
			default:  cur_lr = s.lr_usr;
		endcase
	endfunction

	function automatic logic [31:0] cur_saved(input eecs_state_t s);
		case (s.status[4:0])
			MODE_FIQ: cur_saved = s.saved_fiq;
			MODE_IRQ: cur_saved = s.saved_irq;
			MODE_SVC: cur_saved = s.saved_svc;
			MODE_ABT: cur_saved = s.saved_abt;
			MODE_UND: cur_saved = s.saved_und;
			default:  cur_saved = 32'h00000000;
		endcase
	endfunction

	logic        compact;
	logic [31:0] ret_calc;
	logic [4:0]  tgt_mode;
	logic [31:0] lr_now;
	logic [EVT_W-1:0] evt_set;

	always_comb
	begin
		s_d = s_q;
		evt_set = '0;
		compact = s_q.status[STATE_BIT];
		tgt_mode = mode_of(eecs_exc_t'(exc_kind));
		lr_now = cur_lr(s_q);
		ret_calc = cur_pc - OFS_STD4;
		if (compact)
		begin
			case (eecs_exc_t'(exc_kind))
				EXC_SWI, EXC_UNDEF: ret_calc = cur_pc - OFS_CMP2;
				EXC_FIQ, EXC_IRQ:   ret_calc = cur_pc;
				EXC_PABT:           ret_calc = cur_pc;
				EXC_DABT:           ret_calc = cur_pc + OFS_CMP2;
				default:            ret_calc = cur_pc - OFS_CMP2;
			endcase
		end
		s_d.fetch_load = 1'b0;
		s_d.rdata = 32'h00000000;

		case (s_q.phase)
			ST_IDLE:
			begin
				if (exc_req)
				begin
					s_d.kind = eecs_exc_t'(exc_kind);
					s_d.ret_addr = ret_calc;
					// Saved copy keeps the state flag at bit 5
					case (tgt_mode)
						MODE_FIQ: s_d.saved_fiq = s_q.status;
						MODE_IRQ: s_d.saved_irq = s_q.status;
						MODE_ABT: s_d.saved_abt = s_q.status;
						MODE_UND: s_d.saved_und = s_q.status;
						default:  s_d.saved_svc = s_q.status;
					endcase
					s_d.status[STATE_BIT] = 1'b0;
					s_d.status[4:0] = tgt_mode;
					s_d.status[IRQ_DIS_BIT] = 1'b1;
					if (eecs_exc_t'(exc_kind) == EXC_FIQ)
						s_d.status[FIQ_DIS_BIT] = 1'b1;
					if (eecs_exc_t'(exc_kind) == EXC_SWI)
					begin
						if (compact && swi_opcode[15:8] == CSWI_TOP)
							s_d.swi_num = {16'h0000, swi_opcode[7:0]};
						else
							s_d.swi_num = swi_opcode[23:0];
					end
					evt_set[exc_kind] = 1'b1;
					s_d.phase = ST_LINK;
				end
				else if (bl_req)
				begin
					// Link written now; pc loaded only in the following cycle
					case (s_q.status[4:0])
						MODE_FIQ: s_d.lr_fiq = cur_pc - OFS_STD4;
						MODE_IRQ: s_d.lr_irq = cur_pc - OFS_STD4;
						MODE_SVC: s_d.lr_svc = cur_pc - OFS_STD4;
						MODE_ABT: s_d.lr_abt = cur_pc - OFS_STD4;
						MODE_UND: s_d.lr_und = cur_pc - OFS_STD4;
						default:  s_d.lr_usr = cur_pc - OFS_STD4;
					endcase
					s_d.ret_addr = bl_target;
					s_d.phase = ST_VECTOR;
					s_d.kind = EXC_RESET;
				end
				else if (bx_req)
				begin
					// Exchange picks the state from bit 0 of the target
					s_d.status[STATE_BIT] = bx_target[0];
					s_d.fetch_pc = {bx_target[31:1], 1'b0};
					s_d.fetch_load = 1'b1;
				end
			end
			ST_LINK:
			begin
				case (s_q.status[4:0])
					MODE_FIQ: s_d.lr_fiq = s_q.ret_addr;
					MODE_IRQ: s_d.lr_irq = s_q.ret_addr;
					MODE_ABT: s_d.lr_abt = s_q.ret_addr;
					MODE_UND: s_d.lr_und = s_q.ret_addr;
					default:  s_d.lr_svc = s_q.ret_addr;
				endcase
				s_d.link_out = s_q.ret_addr;
				s_d.ret_addr = vec_of(s_q.kind);
				s_d.phase = ST_VECTOR;
			end
			ST_VECTOR:
			begin
				s_d.fetch_pc = s_q.ret_addr;
				s_d.fetch_load = 1'b1;
				s_d.phase = ST_IDLE;
			end
			default: s_d.phase = ST_IDLE;
		endcase

		// Software mode writes may select system mode and either state, taken from wdata bit 5
		if (wr && s_q.phase == ST_IDLE && !exc_req)
		begin
			case (addr)
				REG_STATUS: s_d.status = wdata;
				REG_USR_LR: s_d.lr_usr = wdata;
				REG_EVT_EN: s_d.evt_en = wdata[EVT_W-1:0];
				default: ;
			endcase
		end
		// Hardware set wins over the clear
		if (wr && addr == REG_EVT_CLR)
			s_d.evt = s_q.evt & ~wdata[EVT_W-1:0];
		s_d.evt = s_d.evt | evt_set;
		if (rd)
		begin
			case (addr)
				REG_STATUS: s_d.rdata = s_q.status;
				REG_SAVED:  s_d.rdata = cur_saved(s_q);
				REG_LINK:   s_d.rdata = lr_now;
				REG_PC:     s_d.rdata = s_q.fetch_pc;
				REG_SWINUM: s_d.rdata = {8'h00, s_q.swi_num};
				REG_EVT:    s_d.rdata = {25'h0000000, s_q.evt};
				REG_EVT_EN: s_d.rdata = {25'h0000000, s_q.evt_en};
				REG_USR_LR: s_d.rdata = s_q.lr_usr;
				default:    s_d.rdata = 32'h00000000;
			endcase
		end
		s_d.irq = |(s_d.evt & s_d.evt_en);
		// Busy is registered so the pipeline never sees a decoded glitch
		s_d.busy = (s_d.phase != ST_IDLE);
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			s_q <= '0;
			s_q.status <= STATUS_RESET;
			s_q.phase <= ST_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign rdata       = s_q.rdata;
	assign fetch_pc    = s_q.fetch_pc;
	assign fetch_load  = s_q.fetch_load;
	assign status_word = s_q.status;
	assign link_out    = s_q.link_out;
	assign busy        = s_q.busy;
	assign irq         = s_q.irq;

	// Entry sequence checks; each starts at the edge that takes a request, in the link or vector phase, or on a branch-link

	state_forced_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req
		|=> !s_q.status[STATE_BIT])
		else $error("standard state not forced on entry");

	mode_set_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req
		|=> s_q.status[4:0] == $past(tgt_mode))
		else $error("mode bits not set to exception mode");

	link_order_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req
		|=> s_q.phase == ST_LINK ##1
		link_out == $past(s_q.ret_addr) ##1 fetch_load)
		else $error("link stored out of order");

	link_bank_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_LINK
		|=> cur_lr(s_q) == $past(s_q.ret_addr))
		else $error("banked link not written");

	link_out_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_LINK
		|=> link_out == $past(s_q.ret_addr))
		else $error("link output not updated");

	vector_load_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req
		|=> ##2 fetch_load)
		else $error("vector not loaded on third cycle");

	vec_same_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_LINK
		|=> s_q.ret_addr == vec_of(s_q.kind))
		else $error("vector depends on state");

	vec_table_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_VECTOR && $past(s_q.phase) == ST_LINK
		|=> fetch_pc == vec_of(s_q.kind))
		else $error("fetch not from vector table");

	std_ret_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && !compact
		|=> s_q.ret_addr == $past(cur_pc) - 32'h00000004)
		else $error("standard return address wrong");

	cmp_swi_ret_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && compact && (exc_kind == EXC_SWI || exc_kind == EXC_UNDEF)
		|=> s_q.ret_addr == $past(cur_pc) - 32'h00000002)
		else $error("compact swi link wrong");

	cmp_int_ret_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && compact && (exc_kind == EXC_FIQ || exc_kind == EXC_IRQ)
		|=> s_q.ret_addr == $past(cur_pc))
		else $error("compact interrupt link wrong");

	cmp_pabt_ret_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && compact && exc_kind == EXC_PABT
		|=> s_q.ret_addr == $past(cur_pc))
		else $error("compact prefetch abort link wrong");

	dabt_ret_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && compact && exc_kind == EXC_DABT
		|=> s_q.ret_addr == $past(cur_pc) + 32'h00000002)
		else $error("compact data abort link wrong");

	saved_flag_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && exc_kind == EXC_IRQ
		|=> s_q.saved_irq[STATE_BIT] == $past(compact))
		else $error("saved state flag wrong");

	saved_fast_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && exc_kind == EXC_FIQ
		|=> s_q.saved_fiq[STATE_BIT] == $past(compact))
		else $error("fast saved state flag wrong");

	swi_short_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && compact && exc_kind == EXC_SWI
		&& swi_opcode[15:8] == CSWI_TOP
		|=> s_q.swi_num[7:0] == $past(swi_opcode[7:0]) && s_q.swi_num[23:8] == 16'h0000)
		else $error("compact swi number wrong");

	swi_long_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req && !compact && exc_kind == EXC_SWI
		|=> s_q.swi_num == $past(swi_opcode[23:0]))
		else $error("standard swi number wrong");

	saved_bank_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_LINK
		|-> cur_saved(s_q) == $past(s_q.status))
		else $error("banked saved status wrong");

	bl_link_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && !exc_req && bl_req && !(wr && addr == REG_STATUS)
		|=> cur_lr(s_q) == $past(cur_pc) - 32'h00000004 ##1 fetch_load)
		else $error("branch link not written before pc");

	bl_target_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && !exc_req && bl_req
		|=> ##1 fetch_load && fetch_pc == $past(bl_target, 2))
		else $error("branch link target wrong");

	usr_link_kept_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req
		|=> s_q.lr_usr == $past(s_q.lr_usr))
		else $error("exception overwrote user link");

	no_sys_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_LINK
		|-> s_q.status[4:0] != MODE_SYS)
		else $error("exception entered system mode");

	entry_no_sys_a: assert property (@(posedge clock) disable iff (srst)
		s_q.phase == ST_IDLE && exc_req
		|=> s_q.status[4:0] != MODE_SYS)
		else $error("entry selected system mode");
endmodule

// File: eecs_pipe_model.sv
// Pipeline model that presents exception and branch-link requests.
// Assumes the entry block takes a request at a rising edge with busy low.
`timescale 1ns/100ps
module eecs_pipe_model
	import eecs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        busy,
	input  wire logic        start,
	input  wire logic [2:0]  kind,
	input  wire logic [31:0] pc,
	input  wire logic [31:0] op,
	output logic             exc_req,
	output logic             bl_req,
	output logic [2:0]       exc_kind,
	output logic [31:0]      cur_pc,
	output logic [31:0]      swi_opcode,
	output logic [31:0]      bl_target
);
	initial
	begin
		exc_req = 1'b0;
		bl_req = 1'b0;
		exc_kind = 3'h0;
		cur_pc = 32'h0;
		swi_opcode = 32'h0;
		bl_target = 32'h0;
	end
	// Kind 7 asks for a branch-link; on release pc, opcode and target are inverted so stale data never matches
	always @(posedge clock)
	begin
		if (srst)
		begin
			exc_req <= 1'b0;
			bl_req <= 1'b0;
		end
		else if (start)
		begin
			exc_req <= (kind != 3'h7);
			bl_req <= (kind == 3'h7);
			exc_kind <= kind;
			cur_pc <= pc;
			swi_opcode <= op;
			bl_target <= op;
		end
		else if (bl_req || (exc_req && !busy))
		begin
			exc_req <= 1'b0;
			bl_req <= 1'b0;
			cur_pc <= ~cur_pc;
			swi_opcode <= ~swi_opcode;
			bl_target <= ~bl_target;
		end
	end
endmodule

// File: exception_entry_compact_state_bench.sv
// Self-checking bench of the exception entry block against a reference model.
// Assumes the pipeline model drives exception and branch-link requests.
`timescale 1ns/100ps
module exception_entry_compact_state_bench
	import eecs_pkg::*;
;
	logic        clock, srst, start, exc_req, bl_req, bx_req, wr, rd;
	logic        fetch_load, busy, irq;
	logic [2:0]  kind, exc_kind;
	logic [3:0]  addr;
	logic [4:0]  md;
	logic [31:0] pc, op, cur_pc, swi_opcode, bl_target, bx_target, wdata, rdata;
	logic [31:0] fetch_pc, status_word, link_out, seed, v, t;
	int          num_errors, checks;
	logic [31:0] vec_tab [7] = '{VEC_RESET, VEC_UNDEF, VEC_SWI, VEC_PABT, VEC_DABT,
		VEC_IRQ, VEC_FIQ};
	logic [4:0]  mode_tab [7] = '{MODE_SVC, MODE_UND, MODE_SVC, MODE_ABT, MODE_ABT,
		MODE_IRQ, MODE_FIQ};

	eecs_exception_entry dut_u (.clock(clock), .srst(srst), .exc_req(exc_req),
		.exc_kind(exc_kind), .cur_pc(cur_pc), .swi_opcode(swi_opcode), .bl_req(bl_req),
		.bl_target(bl_target), .bx_req(bx_req), .bx_target(bx_target), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fetch_pc(fetch_pc),
		.fetch_load(fetch_load), .status_word(status_word), .link_out(link_out),
		.busy(busy), .irq(irq));
	eecs_pipe_model pipe_u (.clock(clock), .srst(srst), .busy(busy), .start(start),
		.kind(kind), .pc(pc), .op(op), .exc_req(exc_req), .bl_req(bl_req),
		.exc_kind(exc_kind), .cur_pc(cur_pc), .swi_opcode(swi_opcode),
		.bl_target(bl_target));

	always #50 clock = ~clock;

	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] lexp(logic [2:0] k, bit c, logic [31:0] p);
		if (!c)
			return p - OFS_STD4;
		case (k)
			EXC_UNDEF, EXC_SWI: return p - OFS_CMP2;
			EXC_DABT: return p + OFS_CMP2;
			default: return p;
		endcase
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(logic [3:0] a, logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_fetch();
		int n;
		n = 0;
		#1;
		while (fetch_load !== 1'b1 && n < 10)
		begin
			@(posedge clock);
			#1 n++;
		end
		chk("fetch_load", 32'h1, {31'h0, fetch_load});
		chk("busy", 32'h0, {31'h0, busy});
	endtask
	task automatic issue(logic [2:0] k, logic [31:0] p, logic [31:0] o);
		@(posedge clock);
		start <= 1'b1;
		kind <= k;
		pc <= p;
		op <= o;
		@(posedge clock);
		start <= 1'b0;
		wait_fetch();
	endtask
	task automatic run(logic [2:0] k, bit c);
		logic [31:0] p, o, sv;
		p = nxt() & (c ? 32'hFFFFFFFE : 32'hFFFFFFFC);
		o = c ? {16'h0000, CSWI_TOP, p[11:4]} : {8'hEF, p[23:16], 1'b0, p[14:0]};
		if (c)
		begin
			@(posedge clock);
			bx_target <= p | 32'h1;
			bx_req <= 1'b1;
			@(posedge clock);
			bx_req <= 1'b0;
			bx_target <= ~bx_target;
			wait_fetch();
			chk("state", 32'h1, {31'h0, status_word[STATE_BIT]});
		end
		issue(k, p, o);
		chk("vector", vec_tab[k], fetch_pc);
		if (k != EXC_RESET)
			chk("link", lexp(k, c, p), link_out);
		chk("mode", {27'h0, mode_tab[k]}, {27'h0, status_word[4:0]});
		chk("state out", 32'h0, {31'h0, status_word[STATE_BIT]});
		rd_reg(REG_SAVED, sv);
		chk("saved", {26'h0, c, md}, {26'h0, sv[5:0]});
		md = mode_tab[k];
		if (k == EXC_SWI)
		begin
			rd_reg(REG_SWINUM, sv);
			chk("swi number", c ? {24'h0, o[7:0]} : {8'h0, o[23:0]}, sv);
		end
	endtask
	task automatic irq_is(logic e);
		repeat (2) @(posedge clock);
		#1 chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task print_verdict();
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#500000 num_errors++;
		print_verdict();
	end
	initial
	begin
		{clock, start, bx_req, wr, rd, kind, addr} = '0;
		{pc, op, bx_target, wdata, num_errors, checks} = '0;
		srst = 1'b1;
		seed = 32'h00017173;
		md = MODE_SVC;
		repeat (5) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		#1 chk("reset status", STATUS_RESET, status_word);
		for (int c = 0; c < 2; c++)
			for (int k = 0; k < 7; k++)
				run(k[2:0], c[0]);
		// Branch-link in an exception mode writes the current banked link
		pc = nxt() & 32'hFFFFFFFC;
		t = nxt() & 32'hFFFFFFFC;
		issue(3'h7, pc, t);
		chk("bl target", t, fetch_pc);
		rd_reg(REG_LINK, v);
		chk("bl link", pc - OFS_STD4, v);
		wr_reg(REG_STATUS, 32'h000000DF);
		md = MODE_SYS;
		t = nxt();
		wr_reg(REG_USR_LR, t);
		run(EXC_IRQ, 1'b0);
		rd_reg(REG_USR_LR, v);
		chk("user link", t, v);
		rd_reg(REG_EVT, v);
		chk("events", 32'h7F, v);
		wr_reg(REG_EVT_EN, 32'h20);
		irq_is(1'b1);
		wr_reg(REG_EVT_CLR, 32'h7F);
		irq_is(1'b0);
		rd_reg(REG_EVT, v);
		chk("cleared", 32'h0, v);
		run(EXC_IRQ, 1'b1);
		irq_is(1'b1);
		wr_reg(REG_EVT_EN, 32'h0);
		irq_is(1'b0);
		wr_reg(REG_EVT_EN, 32'h20);
		irq_is(1'b1);
		wr_reg(REG_EVT_CLR, 32'h20);
		irq_is(1'b0);
		wr_reg(4'hF, 32'hFFFFFFFF);
		rd_reg(4'hF, v);
		chk("unmapped", 32'h0, v);
		print_verdict();
	end
endmodule
